//--- common/spm_params.svh
// constants for the serial peripheral pin and select-mode block
// included by bare name from the design modules
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

// select_mode_field encodings
`define SPM_MODE_3W 2'h0
`define SPM_MODE_MM 2'h1
// position of select_mode_upper_bit and select_mode_lower_bit
`define SPM_MODE_UP 1
`define SPM_MODE_LO 0

// bits exchanged per transfer
`define SPM_BITS 8
// mclk cycles per serial clock half period when master
`define SPM_HALF_DEF 2
// entries of the transmit buffer
`define SPM_BUF_DEPTH 2
// flops in a synchroniser
`define SPM_SYNC_STAGES 2

`endif

//--- common/spm_pkg.sv
// types shared by the serial peripheral pin and select-mode block
// no timescale; used by scoped name only
package spm_pkg;

    typedef enum logic [1:0] {
        mst_idle,
        mst_low,
        mst_high
    } spm_mst_e;

    typedef logic [1:0] spm_mode_t;

endpackage : spm_pkg

//--- core/spm_sync.sv
// two-flop level synchroniser for a bundle of independent bits
// assumes each bit is a slow level or a toggle, never a multi-bit word
`timescale 1ns/1ps
`include "spm_params.svh"

module spm_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else if (clk_en)
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : spm_sync

//--- core/spm_buf2.sv
// small buffer with valid and ready on both sides, default two entries
// assumes both sides sit on mclk
`timescale 1ns/1ps
`include "spm_params.svh"

module spm_buf2 #(
    parameter int W = `SPM_BITS,
    parameter int DEPTH = `SPM_BUF_DEPTH
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk)
    begin
        if (clk_en && push)
            mem_q[wr_q] <= in_data;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule : spm_buf2

//--- core/spm_top.sv
// serial peripheral unit: pin direction, shifting and select modes
// assumes software drives the config ports on mclk; serial clock from
// an outside master arrives on spi_sck_clk and stands still between frames
`timescale 1ns/1ps
`include "spm_params.svh"

module spm_top #(
    parameter int HALF = `SPM_HALF_DEF,
    parameter int BITS = `SPM_BITS
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic spi_sck_clk,
    input wire logic cfg_write,
    input wire logic cfg_master_en,
    input wire logic cfg_unit_en,
    input wire logic [1:0] select_mode_field,
    input wire logic done_clear,
    input wire logic fault_clear,
    input wire logic overrun_clear,
    output logic master_enable_bit,
    output logic unit_enable_bit,
    output logic transfer_done_flag,
    output logic mode_fault_flag,
    output logic rx_overrun_flag,
    input wire logic [BITS-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [BITS-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    output logic sck_out,
    output logic sck_oe,
    input wire logic nss_in,
    output logic nss_out,
    output logic nss_oe,
    output logic nss_pin_mapped
);

    localparam int CW = $clog2(BITS);
    localparam int HW = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] LAST = CW'(BITS-1);
    localparam logic [HW-1:0] HLAST = HW'(HALF-1);
    localparam int BYTE_CYC = 2 * HALF * BITS - 1;
    localparam int BCW = $clog2(2 * HALF * BITS);

    spm_pkg::spm_mode_t mode_q;
    spm_pkg::spm_mst_e mst_q;
    logic master_q;
    logic unit_q;
    logic nss_s;
    logic miso_s;
    logic s_tgl_s;
    logic nss_prev_q;
    logic tgl_prev_q;
    logic mm_fault;
    logic slave_act_d;
    logic slave_act_q;
    logic [BITS-1:0] b_data;
    logic b_valid;
    logic b_ready;
    logic m_take;
    logic s_take;
    logic [HW-1:0] hcnt_q;
    logic [CW-1:0] mbit_q;
    logic [BITS-1:0] msh_q;
    logic [BITS-1:0] msh_d;
    logic [BCW-1:0] byte_cyc_q;
    logic m_done;
    logic s_done;
    logic done_ev;
    logic [BITS-1:0] rx_word;
    logic [BITS-1:0] s_held_q;
    logic s_full_q;
    logic slv_rstn;
    logic [CW-1:0] s_cnt_q;
    logic [BITS-1:0] s_sh_q;
    logic [BITS-1:0] s_sh_d;
    logic [BITS-1:0] s_rx_q;
    logic s_tgl_q;
    logic s_seen_q;
    logic s_msb_q;

    spm_sync #(.W(3)) u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .clk_en(clk_en),
        .d({nss_in, miso_in, s_tgl_q}),
        .q({nss_s, miso_s, s_tgl_s})
    );

    spm_buf2 #(.W(BITS), .DEPTH(`SPM_BUF_DEPTH)) u_txbuf (
        .mclk(mclk),
        .rstn(rstn),
        .clk_en(clk_en),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(b_data),
        .out_valid(b_valid),
        .out_ready(b_ready)
    );

    // falling select in multi-master mode while acting as master
    assign mm_fault = (mode_q == `SPM_MODE_MM) && master_q && unit_q &&
        nss_prev_q && !nss_s;

    // slave selected: always in 3-wire and in modes 1x, by low select in mode 01
    always_comb
    begin
        slave_act_d = 1'b0;
        if (unit_q && !master_q)
        begin
            case (mode_q)
                `SPM_MODE_3W: slave_act_d = 1'b1;
                `SPM_MODE_MM: slave_act_d = !nss_s;
                default: slave_act_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_q <= `SPM_MODE_3W;
            nss_prev_q <= 1'b1;
            tgl_prev_q <= 1'b0;
            slave_act_q <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_q <= select_mode_field;
            nss_prev_q <= nss_s;
            tgl_prev_q <= s_tgl_s;
            slave_act_q <= slave_act_d;
        end
    end

    // enable bits; a mode fault wins over a software write
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            master_q <= 1'b0;
            unit_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (mm_fault)
            begin
                master_q <= 1'b0;
                unit_q <= 1'b0;
            end
            else if (cfg_write)
            begin
                master_q <= cfg_master_en;
                unit_q <= cfg_unit_en;
            end
        end
    end

    assign m_take = (mst_q == spm_pkg::mst_idle) && master_q && unit_q &&
        b_valid && !mm_fault;
    assign s_take = !master_q && !s_full_q && b_valid;
    assign b_ready = m_take || s_take;
    // synced miso already holds the bit seen at the rising sck
    assign msh_d = {msh_q[BITS-2:0], miso_s};

    // master engine: mosi changes on falling sck, miso sampled on rising
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            mst_q <= spm_pkg::mst_idle;
            hcnt_q <= '0;
            mbit_q <= '0;
            msh_q <= '0;
            sck_out <= 1'b0;
            mosi_out <= 1'b0;
        end
        else if (clk_en)
        begin
            case (mst_q)
                spm_pkg::mst_idle:
                begin
                    sck_out <= 1'b0;
                    if (m_take)
                    begin
                        msh_q <= b_data;
                        mosi_out <= b_data[BITS-1];
                        hcnt_q <= '0;
                        mbit_q <= '0;
                        mst_q <= spm_pkg::mst_low;
                    end
                end
                spm_pkg::mst_low:
                begin
                    if (!master_q || !unit_q)
                    begin
                        mst_q <= spm_pkg::mst_idle;
                        sck_out <= 1'b0;
                    end
                    else if (hcnt_q == HLAST)
                    begin
                        hcnt_q <= '0;
                        sck_out <= 1'b1;
                        mst_q <= spm_pkg::mst_high;
                    end
                    else
                        hcnt_q <= hcnt_q + 1'b1;
                end
                spm_pkg::mst_high:
                begin
                    if (!master_q || !unit_q)
                    begin
                        mst_q <= spm_pkg::mst_idle;
                        sck_out <= 1'b0;
                    end
                    else if (hcnt_q == HLAST)
                    begin
                        hcnt_q <= '0;
                        sck_out <= 1'b0;
                        msh_q <= msh_d;
                        mosi_out <= msh_q[BITS-2];
                        if (mbit_q == LAST)
                            mst_q <= spm_pkg::mst_idle;
                        else
                        begin
                            mbit_q <= mbit_q + 1'b1;
                            mst_q <= spm_pkg::mst_low;
                        end
                    end
                    else
                        hcnt_q <= hcnt_q + 1'b1;
                end
                default: mst_q <= spm_pkg::mst_idle;
            endcase
        end
    end

    assign m_done = (mst_q == spm_pkg::mst_high) && (hcnt_q == HLAST) &&
        (mbit_q == LAST) && master_q && unit_q;
    assign s_done = slave_act_q && (s_tgl_s != tgl_prev_q);
    assign done_ev = m_done || s_done;
    assign rx_word = m_done ? msh_d : s_rx_q;

    // flags: a setting event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            transfer_done_flag <= 1'b0;
            mode_fault_flag <= 1'b0;
            rx_overrun_flag <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= '0;
        end
        else if (clk_en)
        begin
            if (done_ev)
                transfer_done_flag <= 1'b1;
            else if (done_clear)
                transfer_done_flag <= 1'b0;
            if (mm_fault)
                mode_fault_flag <= 1'b1;
            else if (fault_clear)
                mode_fault_flag <= 1'b0;
            if (done_ev && rx_valid && !rx_ready)
                rx_overrun_flag <= 1'b1;
            else if (overrun_clear)
                rx_overrun_flag <= 1'b0;
            if (done_ev && !(rx_valid && !rx_ready))
            begin
                rx_data <= rx_word;
                rx_valid <= 1'b1;
            end
            else if (rx_ready)
                rx_valid <= 1'b0;
        end
    end

    // word the slave sends next; held stable until its byte completes
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_held_q <= '0;
            s_full_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (s_take)
            begin
                s_held_q <= b_data;
                s_full_q <= 1'b1;
            end
            else if (s_done)
                s_full_q <= 1'b0;
        end
    end

    // pin directions and select line, all registered
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            mosi_oe <= 1'b0;
            sck_oe <= 1'b0;
            miso_oe <= 1'b0;
            nss_oe <= 1'b0;
            nss_out <= 1'b1;
            nss_pin_mapped <= 1'b0;
            master_enable_bit <= 1'b0;
            unit_enable_bit <= 1'b0;
        end
        else if (clk_en)
        begin
            mosi_oe <= unit_q && master_q;
            sck_oe <= unit_q && master_q;
            miso_oe <= slave_act_d;
            nss_oe <= mode_q[`SPM_MODE_UP];
            nss_out <= mode_q[`SPM_MODE_UP] ? mode_q[`SPM_MODE_LO] : 1'b1;
            nss_pin_mapped <= (mode_q != `SPM_MODE_3W);
            master_enable_bit <= master_q && !mm_fault;
            unit_enable_bit <= unit_q && !mm_fault;
        end
    end

    // slave logic on the outside serial clock, held reset while unselected
    assign slv_rstn = rstn && slave_act_q;
    assign s_sh_d = (s_cnt_q == '0) ? {s_held_q[BITS-2:0], mosi_in} :
        {s_sh_q[BITS-2:0], mosi_in};

    always_ff @(posedge spi_sck_clk or negedge slv_rstn)
    begin
        if (!slv_rstn)
        begin
            s_cnt_q <= '0;
            s_sh_q <= '0;
            s_rx_q <= '0;
            s_tgl_q <= 1'b0;
            s_seen_q <= 1'b0;
        end
        else
        begin
            s_sh_q <= s_sh_d;
            s_seen_q <= 1'b1;
            s_cnt_q <= (s_cnt_q == LAST) ? '0 : s_cnt_q + 1'b1;
            if (s_cnt_q == LAST)
            begin
                s_rx_q <= s_sh_d;
                s_tgl_q <= ~s_tgl_q;
            end
        end
    end

    always_ff @(negedge spi_sck_clk or negedge slv_rstn)
    begin
        if (!slv_rstn)
            s_msb_q <= 1'b0;
        else
            s_msb_q <= (s_cnt_q == '0) ? s_held_q[BITS-1] : s_sh_q[BITS-1];
    end

    // first bit comes from the held word before any serial edge
    assign miso_out = s_seen_q ? s_msb_q : s_held_q[BITS-1];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // mclk cycles since the master engine took its byte
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            byte_cyc_q <= '0;
        else if (clk_en)
            byte_cyc_q <= m_take ? '0 : byte_cyc_q + 1'b1;
    end

    a_mosi_dir: assert property (
        clk_en && master_q && unit_q |=> mosi_oe)
        else $error("mosi not driven as master");
    a_mosi_msb: assert property (
        clk_en && m_take |=> mosi_out == $past(b_data[BITS-1]) ##0
        mst_q == spm_pkg::mst_low)
        else $error("mosi not msb at start");
    a_miso_dir: assert property (
        clk_en && master_q |=> !miso_oe)
        else $error("miso driven as master");
    a_miso_hiz: assert property (
        clk_en && (!unit_q || (!master_q && mode_q == `SPM_MODE_MM &&
        nss_s)) |=> !miso_oe)
        else $error("miso not released");
    a_miso_3wire: assert property (
        clk_en && unit_q && !master_q && mode_q == `SPM_MODE_3W |=> miso_oe)
        else $error("3-wire slave miso off");
    a_sck_owner: assert property (
        clk_en && !master_q |=> !sck_oe ##0
        (mst_q == spm_pkg::mst_idle || !clk_en))
        else $error("sck driven as slave");
    a_fault_trip: assert property (
        clk_en && mm_fault |=> mode_fault_flag && !master_q && !unit_q ##1
        (!mosi_oe || !clk_en))
        else $error("mode fault not taken");
    a_nss_drive: assert property (
        clk_en && mode_q[`SPM_MODE_UP] |=> nss_oe &&
        nss_out == $past(mode_q[`SPM_MODE_LO]))
        else $error("select output wrong");
    a_nss_map: assert property (
        clk_en && mode_q == `SPM_MODE_3W |=> !nss_pin_mapped && !nss_oe)
        else $error("select pin mapped in 3-wire");
    a_done_set: assert property (
        clk_en && m_done |=> transfer_done_flag && rx_valid)
        else $error("done flag missing");
    a_byte_len: assert property (
        clk_en && m_done |-> byte_cyc_q == BCW'(BYTE_CYC))
        else $error("byte length wrong");

    c_master_byte: cover property (m_done);
    c_slave_byte: cover property (s_done);
    c_fault: cover property (mm_fault);
    c_overrun: cover property (done_ev && rx_valid && !rx_ready);

endmodule : spm_top

//--- test/spm_partner.sv
// far side of the serial bus: one slave, or one outside master
// assumes the bench resolves every line and tells it which role to play
`timescale 1ns/1ps

module spm_partner (
    input wire logic slave_on,
    input wire logic sck_line,
    input wire logic mosi_line,
    input wire logic miso_line,
    output logic p_sck,
    output logic p_mosi,
    output logic p_miso
);
    logic [7:0] sl_q = 8'h5A;
    logic cap = 1'b0;

    initial
    begin
        p_sck = 1'b0;
        p_mosi = 1'b0;
    end

    // sole slave on the bus, so it answers whenever clocked with slave_on set
    assign p_miso = sl_q[7];
    always @(posedge sck_line)
    begin
        if (slave_on)
            cap <= mosi_line;
    end
    always @(negedge sck_line)
    begin
        if (slave_on)
            sl_q <= {sl_q[6:0], cap};
    end

    // master role: 64 ns clock only within the frame
    task xfer(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            p_mosi = b[i];
            #32 p_sck = 1'b1;
            r[i] = miso_line;
            #32 p_sck = 1'b0;
        end
        // released line shows the inverse of its last bit
        p_mosi = ~p_mosi;
    endtask : xfer
endmodule : spm_partner

//--- test/spm_top_test.sv
// self-checking bench for the serial pin and select-mode block
// assumes spm_partner as the far side; lines resolved here
`timescale 1ns/1ps

module spm_top_test;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic cfg_write = 1'b0, cfg_master_en = 1'b0, cfg_unit_en = 1'b0;
    logic [1:0] select_mode_field = 2'h0;
    logic done_clear = 1'b0, fault_clear = 1'b0, overrun_clear = 1'b0;
    logic master_enable_bit, unit_enable_bit, transfer_done_flag;
    logic mode_fault_flag, rx_overrun_flag, tx_ready, rx_valid;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data;
    logic tx_valid = 1'b0, rx_ready = 1'b1;
    logic mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe;
    logic nss_out, nss_oe, nss_pin_mapped, p_sck, p_mosi, p_miso;
    logic nss_drv = 1'b1, slave_on = 1'b0, junk = 1'b0;
    int error_cnt = 0, total_checks = 0;
    logic [7:0] rxq [$];
    wire mosi_w = mosi_oe ? mosi_out : p_mosi;
    wire miso_w = miso_oe ? miso_out : (slave_on ? p_miso : junk);
    wire sck_w = sck_oe ? sck_out : p_sck;
    wire nss_w = nss_oe ? nss_out : nss_drv;

    spm_top #(.HALF(2)) i_spm_top (.mclk, .rstn, .clk_en,
        .spi_sck_clk(p_sck), .cfg_write, .cfg_master_en, .cfg_unit_en,
        .select_mode_field, .done_clear, .fault_clear, .overrun_clear,
        .master_enable_bit, .unit_enable_bit, .transfer_done_flag,
        .mode_fault_flag, .rx_overrun_flag, .tx_data, .tx_valid, .tx_ready,
        .rx_data, .rx_valid, .rx_ready, .mosi_in(mosi_w), .mosi_out,
        .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .sck_out, .sck_oe,
        .nss_in(nss_w), .nss_out, .nss_oe, .nss_pin_mapped);

    spm_partner i_spm_partner (.slave_on, .sck_line(sck_w),
        .mosi_line(mosi_w), .miso_line(miso_w), .p_sck, .p_mosi, .p_miso);

    always #50 mclk = ~mclk;
    always @(posedge mclk) junk <= ~junk;
    always @(posedge mclk)
    begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            rxq.push_back(rx_data);
    end

    task wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask : chk8

    task chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1

    task cfg(input logic m, input logic u, input logic [1:0] md);
        @(posedge mclk);
        select_mode_field <= md;
        cfg_master_en <= m;
        cfg_unit_en <= u;
        cfg_write <= 1'b1;
        @(posedge mclk);
        cfg_write <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask : cfg

    task wait_rx(input int n);
        int k;
        k = 0;
        while (rxq.size() < n && k < 1000)
        begin
            @(posedge mclk);
            k++;
        end
        @(negedge mclk);
        if (rxq.size() < n)
        begin
            error_cnt++;
            $display("ERROR %0t: no received byte", $time);
            wrap_up();
        end
    endtask : wait_rx

    task clear_done();
        @(posedge mclk);
        done_clear <= 1'b1;
        @(posedge mclk);
        done_clear <= 1'b0;
        @(negedge mclk);
    endtask : clear_done

    task t_master3();
        logic [7:0] b [4];
        logic full;
        int k;
        b = '{8'hA5, 8'h3C, 8'h0F, 8'h96};
        full = 1'b0;
        slave_on = 1'b1;
        cfg(1'b1, 1'b1, 2'h0);
        chk1(mosi_oe, 1'b1);
        chk1(sck_oe, 1'b1);
        chk1(miso_oe, 1'b0);
        chk1(nss_pin_mapped, 1'b0);
        chk1(nss_oe, 1'b0);
        chk1(master_enable_bit, 1'b1);
        rxq.delete();
        @(posedge mclk);
        for (int i = 0; i < 4; i++)
        begin
            tx_data <= b[i];
            tx_valid <= 1'b1;
            k = 0;
            do
            begin
                @(posedge mclk);
                k++;
                if (tx_ready !== 1'b1)
                    full = 1'b1;
            end
            while (tx_ready !== 1'b1 && k < 200);
            if (tx_ready !== 1'b1)
            begin
                error_cnt++;
                $display("ERROR %0t: transmit buffer stuck", $time);
                wrap_up();
            end
        end
        tx_valid <= 1'b0;
        wait_rx(4);
        chk1(full, 1'b1);
        chk8(rxq[0], 8'h5A);
        chk8(rxq[1], 8'hA5);
        chk8(rxq[2], 8'h3C);
        chk8(rxq[3], 8'h0F);
        chk1(transfer_done_flag, 1'b1);
        clear_done();
        chk1(transfer_done_flag, 1'b0);
        repeat (40) @(posedge mclk);
        slave_on = 1'b0;
    endtask : t_master3

    task t_mode1x();
        for (int m = 2; m < 4; m++)
        begin
            cfg(1'b1, 1'b1, m[1:0]);
            chk1(nss_oe, 1'b1);
            chk1(nss_out, m[0]);
            chk1(nss_pin_mapped, 1'b1);
        end
    endtask : t_mode1x

    task t_fault();
        cfg(1'b1, 1'b1, 2'h1);
        chk1(nss_oe, 1'b0);
        chk1(nss_pin_mapped, 1'b1);
        chk1(mode_fault_flag, 1'b0);
        @(posedge mclk);
        nss_drv <= 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk1(mode_fault_flag, 1'b1);
        chk1(master_enable_bit, 1'b0);
        chk1(unit_enable_bit, 1'b0);
        @(posedge mclk);
        nss_drv <= 1'b1;
        fault_clear <= 1'b1;
        @(posedge mclk);
        fault_clear <= 1'b0;
        @(negedge mclk);
        chk1(mode_fault_flag, 1'b0);
    endtask : t_fault

    task t_slave3();
        logic [7:0] r;
        cfg(1'b0, 1'b1, 2'h0);
        @(posedge mclk);
        tx_data <= 8'hC3;
        tx_valid <= 1'b1;
        @(posedge mclk);
        tx_valid <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk1(miso_oe, 1'b1);
        chk1(mosi_oe, 1'b0);
        chk1(sck_oe, 1'b0);
        chk1(nss_pin_mapped, 1'b0);
        rxq.delete();
        i_spm_partner.xfer(8'h69, 8, r);
        i_spm_partner.xfer(8'h1E, 8, r);
        wait_rx(2);
        chk8(r, 8'hC3);
        chk8(rxq[0], 8'h69);
        chk8(rxq[1], 8'h1E);
        cfg(1'b0, 1'b0, 2'h0);
        chk1(miso_oe, 1'b0);
    endtask : t_slave3

    task t_slave4();
        logic [7:0] r;
        cfg(1'b0, 1'b1, 2'h1);
        clear_done();
        chk1(miso_oe, 1'b0);
        rxq.delete();
        i_spm_partner.xfer(8'hFF, 8, r);
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk1(transfer_done_flag, 1'b0);
        @(posedge mclk);
        nss_drv <= 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk1(miso_oe, 1'b1);
        i_spm_partner.xfer(8'hAA, 3, r);
        @(posedge mclk);
        nss_drv <= 1'b1;
        repeat (6) @(posedge mclk);
        nss_drv <= 1'b0;
        repeat (6) @(posedge mclk);
        i_spm_partner.xfer(8'h96, 8, r);
        wait_rx(1);
        chk8(rxq[0], 8'h96);
        @(posedge mclk);
        rx_ready <= 1'b0;
        i_spm_partner.xfer(8'h33, 8, r);
        i_spm_partner.xfer(8'hCC, 8, r);
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk1(rx_overrun_flag, 1'b1);
        chk8(rx_data, 8'h33);
        @(posedge mclk);
        rx_ready <= 1'b1;
        overrun_clear <= 1'b1;
        @(posedge mclk);
        overrun_clear <= 1'b0;
        @(negedge mclk);
        chk1(rx_overrun_flag, 1'b0);
    endtask : t_slave4

    initial
    begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk1(nss_out, 1'b1);
        chk1(tx_ready, 1'b1);
        chk1(miso_oe, 1'b0);
        @(posedge mclk);
        rstn <= 1'b1;
        t_master3();
        t_mode1x();
        t_fault();
        t_slave3();
        t_slave4();
        wrap_up();
    end
endmodule : spm_top_test
